/* verilog/rx_fmt_pkg.sv */
// Notes on behaviour
// R1: Single-rail NRZ mode drives decoded receive data on the positive-rail pin.
// R2: Single-rail decoded data changes only on the chosen recovered clock edge.
// R3: Polarity bit 3 of second config register sets single-rail data level.
// R4: Powered down, single-rail data floats or drives low per bit 6 of first.
// R5: Dual-rail modes use the two shared pins as positive and negative data.
// R6: Dual-rail NRZ puts undecoded NRZ rails out on the active clock edge.
// R7: Dual-rail RZ puts undecoded RZ rails out on the active clock edge.
// R8: Dual-rail sliced mode passes raw slicer rails straight to the pins.
// R9: Differential input: positive tip pulse gives positive rail, else negative.
// R10: Single-ended input: positive tip pulse positive rail, negative pulse negative.
// R11: The same polarity bit 3 sets the level of both dual-rail outputs.
// R12: Powered down, both dual-rail outputs float or drive low per bit 6.
// R13: Single-rail NRZ mode uses the negative-rail pin as indication output.
// R14: Bits 7 to 5 of second config register pick one of eight indications.
// R15: Indication output changes only on the active recovered clock edge, except the recovered clock choice, which follows the clock.
// R16: Indication output is always active high, ignoring the polarity bit.
// R17: Powered down, indication output floats or drives low per bit 6.
// R18: Bit 4 of second config register picks the recovered clock active edge.
// R19: The encoding of the eight indication choices is a package constant.
// R20: Framer samples outputs on the active edge, except in sliced mode.
package rx_fmt_pkg;

	localparam int NUM_CH = 17;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;

	// Word offsets within a channel's group of four registers
	localparam logic [1:0] REG_CFG_FIRST  = 2'h0;
	localparam logic [1:0] REG_CFG_SECOND = 2'h1;
	localparam logic [1:0] REG_MODE       = 2'h2;
	localparam logic [1:0] REG_STATUS     = 2'h3;

	// First receive configuration register fields
	localparam int CF1_CLK_HIGH_BIT  = 7;
	localparam int CF1_FLOAT_BIT     = 6;
	localparam int CF1_POWERDOWN_BIT = 5;
	localparam logic [7:0] CF1_RESET = 8'h00;

	// Second receive configuration register fields
	localparam int CF2_IND_LSB  = 5;
	localparam int CF2_EDGE_BIT = 4;
	localparam int CF2_POL_BIT  = 3;
	localparam logic [7:0] CF2_RESET = 8'h00;

	// Status register fields
	localparam int ST_SYNC_BIT  = 0;
	localparam int ST_AIS_BIT   = 1;
	localparam int ST_EXZ_BIT   = 2;
	localparam int ST_BPV_BIT   = 3;
	localparam int ST_LOS_BIT   = 4;
	localparam int ST_PD_BIT    = 5;

	// Indication select encoding
	localparam logic [2:0] IND_PATTERN_SYNC = 3'h0;
	localparam logic [2:0] IND_ALARM        = 3'h1;
	localparam logic [2:0] IND_EXCESS_ZEROS = 3'h2;
	localparam logic [2:0] IND_BIPOLAR_VIOL = 3'h3;
	localparam logic [2:0] IND_EXZ_OR_BPV   = 3'h4;
	localparam logic [2:0] IND_LOSS_SIGNAL  = 3'h5;
	localparam logic [2:0] IND_REC_CLOCK    = 3'h6;
	localparam logic [2:0] IND_SLICED_XOR   = 3'h7;

	typedef enum logic [1:0] {
		MODE_SINGLE_NRZ,
		MODE_DUAL_NRZ,
		MODE_DUAL_RZ,
		MODE_DUAL_SLICED
	} rx_mode_e;

	// Per-channel signals from the line side, recovered clock domain
	typedef struct packed {
		logic rec_clk;
		logic decoded;
		logic pos_nrz;
		logic neg_nrz;
		logic pos_rz;
		logic neg_rz;
		logic pos_sliced;
		logic neg_sliced;
		logic test_pattern_sync;
		logic line_alarm_indication;
		logic line_excess_zeros;
		logic line_bipolar_violation;
		logic line_loss_of_signal;
	} rx_line_s;

	typedef struct packed {
		rx_mode_e   mode;
		logic [2:0] indication_select_field;
		logic       rx_clock_edge_sel;
		logic       rx_data_polarity_sel;
		logic       powered_down;
		logic       rx_powerdown_float_sel;
	} rx_cfg_s;

	// Two shared pins, each as level and output enable
	typedef struct packed {
		logic p;
		logic p_oe;
		logic n;
		logic n_oe;
	} rx_pins_s;

endpackage : rx_fmt_pkg

/* verilog/rx_channel_formatter.sv */
`timescale 1ns/1ps
module rx_channel_formatter
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Synchronised line-side signals
	input  rx_fmt_pkg::rx_line_s    line_sync,
	// Channel configuration
	input  rx_fmt_pkg::rx_cfg_s     cfg,
	// System-side pins
	output rx_fmt_pkg::rx_pins_s    pins
);

	logic       clk_prev_q;
	logic       active_edge;
	logic       ind_d;
	logic       pol;
	logic       p_q;
	logic       n_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			clk_prev_q <= 1'b0;
		else
			clk_prev_q <= line_sync.rec_clk;
	end

	// High selects the falling edge
	assign active_edge = cfg.rx_clock_edge_sel ?
		(clk_prev_q & ~line_sync.rec_clk) :
		(~clk_prev_q & line_sync.rec_clk); // see R18

	assign pol = cfg.rx_data_polarity_sel;

	always_comb
	begin
		case (cfg.indication_select_field) // see R14 see R19
			rx_fmt_pkg::IND_PATTERN_SYNC:
				ind_d = line_sync.test_pattern_sync;
			rx_fmt_pkg::IND_ALARM:
				ind_d = line_sync.line_alarm_indication;
			rx_fmt_pkg::IND_EXCESS_ZEROS:
				ind_d = line_sync.line_excess_zeros;
			rx_fmt_pkg::IND_BIPOLAR_VIOL:
				ind_d = line_sync.line_bipolar_violation;
			rx_fmt_pkg::IND_EXZ_OR_BPV:
				ind_d = line_sync.line_excess_zeros |
					line_sync.line_bipolar_violation;
			rx_fmt_pkg::IND_LOSS_SIGNAL:
				ind_d = line_sync.line_loss_of_signal;
			rx_fmt_pkg::IND_REC_CLOCK:
				ind_d = line_sync.rec_clk;
			rx_fmt_pkg::IND_SLICED_XOR:
				ind_d = line_sync.pos_sliced ^ line_sync.neg_sliced;
			default:
				ind_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			p_q <= 1'b0;
			n_q <= 1'b0;
		end
		else if (cfg.powered_down)
		begin
			p_q <= 1'b0; // see R4 see R12
			n_q <= 1'b0; // see R17
		end
		else
		begin
			case (cfg.mode)
				rx_fmt_pkg::MODE_SINGLE_NRZ:
				begin
					if (active_edge)
						p_q <= line_sync.decoded ^ pol; // see R1 see R2 see R3
					// Clock choice follows the clock, not its edge
					if (cfg.indication_select_field ==
						rx_fmt_pkg::IND_REC_CLOCK)
						n_q <= line_sync.rec_clk;
					else if (active_edge)
						n_q <= ind_d; // see R13 see R15 see R16
				end
				rx_fmt_pkg::MODE_DUAL_NRZ:
				begin
					if (active_edge)
					begin
						p_q <= line_sync.pos_nrz ^ pol; // see R5 see R6 see R11
						n_q <= line_sync.neg_nrz ^ pol; // see R6 see R11
					end
				end
				rx_fmt_pkg::MODE_DUAL_RZ:
				begin
					if (active_edge)
					begin
						p_q <= line_sync.pos_rz ^ pol; // see R7 see R11
						n_q <= line_sync.neg_rz ^ pol; // see R7 see R11
					end
				end
				rx_fmt_pkg::MODE_DUAL_SLICED:
				begin
					// Positive tip pulse is the positive rail
					p_q <= line_sync.pos_sliced ^ pol; // see R8 see R9 see R10
					n_q <= line_sync.neg_sliced ^ pol; // see R8 see R9 see R10
				end
				default:
				begin
					p_q <= 1'b0;
					n_q <= 1'b0;
				end
			endcase
		end
	end

	assign pins.p    = p_q;
	assign pins.n    = n_q;
	assign pins.p_oe = ~(cfg.powered_down & cfg.rx_powerdown_float_sel);
	assign pins.n_oe = ~(cfg.powered_down & cfg.rx_powerdown_float_sel);

endmodule : rx_channel_formatter

/* verilog/rx_system_output_formatter.sv */
`timescale 1ns/1ps
module rx_system_output_formatter
(
	// Clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   reset_n,
	// Avalon-MM slave
	input  wire logic [rx_fmt_pkg::ADDR_W-1:0]          address,
	input  wire logic                                   read,
	input  wire logic                                   write,
	input  wire logic [3:0]                             byteenable,
	input  wire logic [rx_fmt_pkg::DATA_W-1:0]          writedata,
	output logic      [rx_fmt_pkg::DATA_W-1:0]          readdata,
	output logic                                        waitrequest,
	// Line-side signals, one struct per channel
	input  rx_fmt_pkg::rx_line_s [rx_fmt_pkg::NUM_CH-1:0] line_in,
	// System-side pins, one struct per channel
	output rx_fmt_pkg::rx_pins_s [rx_fmt_pkg::NUM_CH-1:0] pins_out
);

	localparam int CH_W = rx_fmt_pkg::ADDR_W - 2;

	rx_fmt_pkg::rx_line_s [rx_fmt_pkg::NUM_CH-1:0] line_meta_q;
	rx_fmt_pkg::rx_line_s [rx_fmt_pkg::NUM_CH-1:0] line_sync_q;
	rx_fmt_pkg::rx_cfg_s  [rx_fmt_pkg::NUM_CH-1:0] cfg;

	logic [7:0] cf1_q [rx_fmt_pkg::NUM_CH];
	logic [7:0] cf2_q [rx_fmt_pkg::NUM_CH];
	logic [1:0] mode_q [rx_fmt_pkg::NUM_CH];

	logic            ack_q;
	logic            req;
	logic [CH_W-1:0] ch_idx;
	logic [1:0]      reg_idx;
	logic            ch_ok;
	logic [7:0]      rd_d;
	logic [31:0]     readdata_q;

	// Bus handshake: one wait cycle per access
	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign ch_idx      = address[rx_fmt_pkg::ADDR_W-1:2];
	assign reg_idx     = address[1:0];
	assign ch_ok       = ({27'h0, ch_idx} < rx_fmt_pkg::NUM_CH);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// Configuration registers, written in the completing cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < rx_fmt_pkg::NUM_CH; i++)
			begin
				cf1_q[i]  <= rx_fmt_pkg::CF1_RESET;
				cf2_q[i]  <= rx_fmt_pkg::CF2_RESET;
				mode_q[i] <= 2'h0;
			end
		end
		else if (write && ack_q && ch_ok && byteenable[0])
		begin
			for (int i = 0; i < rx_fmt_pkg::NUM_CH; i++)
			begin
				if ({27'h0, ch_idx} == i)
				begin
					case (reg_idx)
						rx_fmt_pkg::REG_CFG_FIRST:
							cf1_q[i] <= writedata[7:0] & 8'hE0;
						rx_fmt_pkg::REG_CFG_SECOND:
							cf2_q[i] <= writedata[7:0] & 8'hF8;
						rx_fmt_pkg::REG_MODE:
							mode_q[i] <= writedata[1:0];
						default:
							;
					endcase
				end
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_d = 8'h00;
		for (int i = 0; i < rx_fmt_pkg::NUM_CH; i++)
		begin
			if ({27'h0, ch_idx} == i)
			begin
				case (reg_idx)
					rx_fmt_pkg::REG_CFG_FIRST:
						rd_d = cf1_q[i];
					rx_fmt_pkg::REG_CFG_SECOND:
						rd_d = cf2_q[i];
					rx_fmt_pkg::REG_MODE:
						rd_d = {6'h00, mode_q[i]};
					rx_fmt_pkg::REG_STATUS:
					begin
						rd_d[rx_fmt_pkg::ST_SYNC_BIT] =
							line_sync_q[i].test_pattern_sync;
						rd_d[rx_fmt_pkg::ST_AIS_BIT] =
							line_sync_q[i].line_alarm_indication;
						rd_d[rx_fmt_pkg::ST_EXZ_BIT] =
							line_sync_q[i].line_excess_zeros;
						rd_d[rx_fmt_pkg::ST_BPV_BIT] =
							line_sync_q[i].line_bipolar_violation;
						rd_d[rx_fmt_pkg::ST_LOS_BIT] =
							line_sync_q[i].line_loss_of_signal;
						rd_d[rx_fmt_pkg::ST_PD_BIT] =
							cf1_q[i][rx_fmt_pkg::CF1_POWERDOWN_BIT];
					end
					default:
						rd_d = 8'h00;
				endcase
			end
		end
	end

	// Read data captured in the wait cycle, stable when waitrequest drops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			readdata_q <= 32'h0000_0000;
		else if (read && !ack_q)
			readdata_q <= {24'h000000, rd_d};
	end

	assign readdata = readdata_q;

	genvar g;
	generate
		for (g = 0; g < rx_fmt_pkg::NUM_CH; g++)
		begin : g_ch
			// Two-flop synchroniser for the recovered clock domain
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					line_meta_q[g] <= '0;
					line_sync_q[g] <= '0;
				end
				else
				begin
					line_meta_q[g] <= line_in[g];
					line_sync_q[g] <= line_meta_q[g];
				end
			end

			assign cfg[g].mode = rx_fmt_pkg::rx_mode_e'(mode_q[g]);
			assign cfg[g].indication_select_field =
				cf2_q[g][rx_fmt_pkg::CF2_IND_LSB +: 3]; // see R14
			assign cfg[g].rx_clock_edge_sel =
				cf2_q[g][rx_fmt_pkg::CF2_EDGE_BIT]; // see R18
			assign cfg[g].rx_data_polarity_sel =
				cf2_q[g][rx_fmt_pkg::CF2_POL_BIT]; // see R3 see R11
			assign cfg[g].powered_down =
				cf1_q[g][rx_fmt_pkg::CF1_POWERDOWN_BIT];
			assign cfg[g].rx_powerdown_float_sel =
				cf1_q[g][rx_fmt_pkg::CF1_FLOAT_BIT]; // see R4 see R12 see R17

			rx_channel_formatter u_fmt
			(
				.clk       (clk),
				.reset_n   (reset_n),
				.line_sync (line_sync_q[g]),
				.cfg       (cfg[g]),
				.pins      (pins_out[g])
			);
		end
	endgenerate

endmodule : rx_system_output_formatter

/* dv/rx_fmt_assertions.sv */
`timescale 1ns/1ps
module rx_fmt_assertions
(
	// Clock, reset and bus
	input wire logic				clk,
	input wire logic				reset_n,
	input wire logic [rx_fmt_pkg::ADDR_W-1:0]	address,
	input wire logic				read,
	input wire logic				write,
	input wire logic [3:0]				byteenable,
	input wire logic [rx_fmt_pkg::DATA_W-1:0]	writedata,
	input wire logic [rx_fmt_pkg::DATA_W-1:0]	readdata,
	input wire logic				waitrequest,
	// Line side and pins
	input wire rx_fmt_pkg::rx_line_s [rx_fmt_pkg::NUM_CH-1:0]	line_in,
	input wire rx_fmt_pkg::rx_pins_s [rx_fmt_pkg::NUM_CH-1:0]	pins_out
);
	logic [7:0]	cf1_q;
	logic [7:0]	cf2_q;
	logic [1:0]	mode_q;
	logic [2:0]	since_q;
	logic		rc_q;
	wire		wr0 = write && !waitrequest && byteenable[0]
			&& address[6:2] == 5'h00;

	// Channel 0 configuration shadow
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			{cf1_q, cf2_q, mode_q} <= 18'h00000;
		else if (wr0 && address[1:0] == 2'h0)
			cf1_q <= writedata[7:0];
		else if (wr0 && address[1:0] == 2'h1)
			cf2_q <= writedata[7:0];
		else if (wr0 && address[1:0] == 2'h2)
			mode_q <= writedata[1:0];

	// Cycles since the last active recovered clock edge
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			rc_q <= 1'b0;
			since_q <= 3'h7;
		end
		else
		begin
			rc_q <= line_in[0].rec_clk;
			if (rc_q != line_in[0].rec_clk && line_in[0].rec_clk != cf2_q[4])
				since_q <= 3'h0;
			else if (since_q != 3'h7)
				since_q <= since_q + 3'h1;
		end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_sliced_quiet;
		(mode_q == 2'h3 && !cf1_q[5] && $stable(line_in[0].pos_sliced)
		&& $stable(cf2_q[3]))[*5];
	endsequence
	sequence s_clk_quiet;
		(mode_q == 2'h0 && cf2_q[7:5] == 3'h6 && !cf1_q[5]
		&& $stable(line_in[0].rec_clk))[*5];
	endsequence

	a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait lasted over one cycle");
	a_unmapped_zero: assert property (read && !waitrequest
		&& address[6:2] > 5'h10 |-> readdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (read && !waitrequest
		|-> readdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_float_off: assert property (
		cf1_q[5] && cf1_q[6] |-> !pins_out[0].p_oe && !pins_out[0].n_oe)
		else $error("pins driven while floating");
	a_drive_low: assert property (
		cf1_q[5] && !cf1_q[6] |-> (pins_out[0].p_oe && pins_out[0].n_oe)
		##1 (!pins_out[0].p && !pins_out[0].n))
		else $error("powered-down pins not low");
	a_sliced_follow: assert property (s_sliced_quiet
		|-> pins_out[0].p == (line_in[0].pos_sliced ^ cf2_q[3]))
		else $error("sliced rail not passed");
	a_ind_clock: assert property (s_clk_quiet
		|-> pins_out[0].n == line_in[0].rec_clk)
		else $error("clock indication wrong");
	a_edge_only: assert property (mode_q != 2'h3 && !cf1_q[5]
		&& !(mode_q == 2'h0 && cf2_q[7:5] == 3'h6)
		&& ($changed(pins_out[0].p) || $changed(pins_out[0].n))
		|-> since_q inside {[3'h1:3'h6]})
		else $error("pin moved off the active edge");
endmodule : rx_fmt_assertions

bind rx_system_output_formatter rx_fmt_assertions i_chk (.clk(clk),
	.reset_n(reset_n), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .line_in(line_in), .pins_out(pins_out));

/* dv/line_source.sv */
`timescale 1ns/1ps
module line_source
(
	// Clock and control
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	run,
	input wire logic	fall,
	input wire logic [11:0]	bits,
	// Line side of one channel
	output rx_fmt_pkg::rx_line_s	line
);
	logic [2:0]	cnt_q;

	// Clock stands still when idle; data moves on the inactive edge
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			cnt_q <= 3'h0;
			line <= 13'h0000;
		end
		else if (run)
		begin
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == 3'h7)
			begin
				line.rec_clk <= !line.rec_clk;
				if (line.rec_clk != fall)
					line[11:0] <= bits;
			end
		end
endmodule : line_source

/* dv/rx_system_output_formatter_bench.sv */
`timescale 1ns/1ps
module rx_system_output_formatter_bench;
	logic		clk;
	logic		reset_n;
	logic [6:0]	address;
	logic		read;
	logic		write;
	logic [31:0]	writedata;
	logic [3:0]	byteenable;
	logic [31:0]	readdata;
	logic		waitrequest;
	logic		run;
	logic		fall;
	logic [11:0]	bits;
	logic [31:0]	q;
	int		errors;
	int		compares;
	int		seed;
	int		m;
	int		sel;
	int		pol;
	int		e;
	wire rx_fmt_pkg::rx_line_s [16:0]	line_all;
	rx_fmt_pkg::rx_pins_s [16:0]		pins;

	assign line_all[16:1] = '0;
	line_source i_src (.clk(clk), .reset_n(reset_n), .run(run), .fall(fall),
		.bits(bits), .line(line_all[0]));
	rx_system_output_formatter i_dut (.clk(clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write),
		.byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .line_in(line_all), .pins_out(pins));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end

	task automatic report_and_stop();
		$display("TB: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h000000, d};
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (n == 20)
		begin
			errors++;
			report_and_stop();
		end
		// Answer and read data both taken at the completing edge
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : xfer

	// Run three recovered clock periods, then let the pins settle
	task automatic burst();
		bits <= 12'($random(seed));
		@(posedge clk);
		run <= 1'b1;
		repeat (48) @(posedge clk);
		run <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : burst

	function automatic logic [1:0] model(int m, int sel, int pol, logic [12:0] l);
		logic [7:0] ind;
		ind = {l[6] ^ l[5], l[12], l[0], l[2] | l[1], l[1], l[2], l[3], l[4]};
		case (m)
			0: model = {l[11] ^ pol[0], ind[sel]};
			1: model = {l[10], l[9]} ^ {2{pol[0]}};
			2: model = {l[8], l[7]} ^ {2{pol[0]}};
			default: model = {l[6], l[5]} ^ {2{pol[0]}};
		endcase
	endfunction : model

	initial
	begin
		seed = 32'h2500a6f3;
		reset_n = 1'b0;
		{read, write, run, fall} = 4'h0;
		address = 7'h00;
		writedata = 32'h00000000;
		byteenable = 4'h1;
		bits = 12'h000;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		for (m = 0; m < 4; m++)
		begin
			xfer(1'b0, 7'(m), 8'h00);
			chk(q, 32'h00000000);
		end
		xfer(1'b1, 7'h44, 8'hFF);
		xfer(1'b0, 7'h44, 8'h00);
		chk(q, 32'h00000000);
		// Last channel floated while powered down, others untouched
		xfer(1'b1, 7'h40, 8'h60);
		xfer(1'b0, 7'h40, 8'h00);
		chk(q, 32'h00000060);
		for (int c = 1; c < 17; c++)
			chk(32'(pins[c]), (c == 16) ? 32'h0 : 32'h5);
		e = $random(seed);
		xfer(1'b1, 7'h01, 8'(e));
		xfer(1'b0, 7'h01, 8'h00);
		chk(q, 32'(e & 8'hF8));
		// Lane 0 disabled: the write must be ignored
		byteenable <= 4'h0;
		xfer(1'b1, 7'h01, 8'hFF);
		byteenable <= 4'h1;
		xfer(1'b0, 7'h01, 8'h00);
		chk(q, 32'(e & 8'hF8));
		$display("TB: registers done");
		for (int i = 0; i < 11; i++)
		begin
			m = (i < 8) ? 0 : i - 7;
			sel = i % 8;
			pol = $random(seed) & 1;
			e = $random(seed) & 1;
			xfer(1'b1, 7'h02, 8'(m));
			xfer(1'b1, 7'h01, 8'(sel * 32 + e * 16 + pol * 8));
			fall <= e[0];
			burst();
			chk(32'({pins[0].p, pins[0].n}), 32'(model(m, sel, pol, line_all[0])));
		end
		$display("TB: modes done");
		for (int f = 0; f < 2; f++)
		begin
			xfer(1'b1, 7'h00, 8'(f * 64 + 32));
			xfer(1'b0, 7'h03, 8'h00);
			chk(q, {26'h0, 1'b1, line_all[0][0], line_all[0][1], line_all[0][2], line_all[0][3], line_all[0][4]});
			chk(32'({pins[0].p_oe, pins[0].n_oe}), (f == 1) ? 32'h0 : 32'h3);
			if (f == 0)
				chk(32'({pins[0].p, pins[0].n}), 32'h0);
		end
		xfer(1'b1, 7'h00, 8'h00);
		burst();
		chk(32'({pins[0].p, pins[0].n}), 32'(model(m, sel, pol, line_all[0])));
		$display("TB: power down done");
		report_and_stop();
	end
endmodule : rx_system_output_formatter_bench
